// ---- sim/odwcd_decoder_tb.sv ----
// Self-checking bench for the write-command decoder.
// Assumes the host model drives the link and this bench drives the pins.
`timescale 1ns/1ps
module odwcd_decoder_tb;
    logic             core_clk, rst_n, load_n, clear_n;
    logic             link_clk, link_start, link_byte_valid;
    logic [7:0]       link_byte, msk;
    logic [7:0][11:0] dac_code;
    logic [7:0][1:0]  chan_power_mode;
    logic [9:0]       channel_power_control;
    logic [1:0]       clear_code_select, c;
    logic [7:0]       load_pin_mask;
    logic             hs_mode, frame_done, frame_drop;
    int               miscompares, total_checks, cycles;
    // Expected clear targets per code; code 3 leaves the output alone
    logic [11:0]      clr_exp [4] = '{12'h000, 12'h800, 12'hfff, 12'habc};
    logic [1:0]       rk [6] = '{2'h2, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
    logic             hx [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    odwcd_host_model host (.link_clk(link_clk), .link_start(link_start),
        .link_byte_valid(link_byte_valid), .link_byte(link_byte));
    odwcd_decoder dut (.core_clk(core_clk), .rst_n(rst_n),
        .link_clk(link_clk), .link_start(link_start),
        .link_byte_valid(link_byte_valid), .link_byte(link_byte),
        .load_update_pin_n(load_n), .async_clear_pin_n(clear_n),
        .dac_code(dac_code), .chan_power_mode(chan_power_mode),
        .channel_power_control(channel_power_control),
        .clear_code_select(clear_code_select),
        .load_pin_mask(load_pin_mask), .hs_mode(hs_mode),
        .frame_done(frame_done), .frame_drop(frame_drop));

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One frame; bounded wait for completion, then the spacing gap
    task automatic frame(input logic [7:0] b0, b1, b2, input logic drop);
        int n;
        n = 0;
        fork host.send(b0, b1, b2); join_none
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (frame_done !== 1'b1 && n < 40);
        chk("frame_done", 1'b1, frame_done);
        chk("frame_drop", drop, frame_drop);
        repeat (8) @(posedge core_clk);
    endtask : frame

    // Hold a pin low five cycles, past the synchroniser
    task automatic pulse_clear();
        @(posedge core_clk) clear_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 @(posedge core_clk) clear_n <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : pulse_clear

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Hang guard: the whole sequence needs about 300 cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        rst_n = 1'b0; load_n = 1'b1; clear_n = 1'b1;
        cycles = 0; miscompares = 0; total_checks = 0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("power ctrl", 10'h000, channel_power_control);
        frame(8'h30, 8'hab, 8'hcd, 1'b0);
        chk("code A", 12'habc, dac_code[0]);
        chk("code H", 12'h000, dac_code[7]);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i + 3);
            frame(8'h50, 8'h00, {2'h0, c, 4'h0}, 1'b0);
            chk("clear sel", c, clear_code_select);
            @(posedge core_clk) clear_n <= 1'b0;
            repeat (4) @(posedge core_clk);
            #1 chk("clear A", clr_exp[c], dac_code[0]);
            @(posedge core_clk) clear_n <= 1'b1;
        end
        frame(8'h27, 8'h12, 8'h3f, 1'b0);
        chk("code A", 12'habc, dac_code[0]);
        chk("code H", 12'h123, dac_code[7]);
        frame(8'h28, 8'h77, 8'h70, 1'b1);
        frame(8'h90, 8'h77, 8'h70, 1'b1);
        chk("code H", 12'h123, dac_code[7]);
        frame(8'h2f, 8'h55, 8'h60, 1'b0);
        chk("code D", 12'h556, dac_code[3]);
        frame(8'h60, 8'hfe, 8'h00, 1'b0);
        chk("load mask", 8'hfe, load_pin_mask);
        pulse_clear();
        @(posedge core_clk) load_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk("code A", 12'h556, dac_code[0]);
        chk("code B", 12'hfff, dac_code[1]);
        @(posedge core_clk) load_n <= 1'b1;
        for (int m = 1; m < 5; m++) begin
            c = 2'(m);
            msk = (m < 4) ? 8'(1 << m) : 8'h0e;
            frame(8'h40, {1'b0, c, msk[7:3]}, {msk[2:0], 5'h0}, 1'b0);
            chk("power ctrl", {c, msk}, channel_power_control);
            chk("power mode", c, chan_power_mode[m < 4 ? m : 1]);
        end
        for (int i = 0; i < 6; i++) begin
            frame(8'h70, {rk[i], 6'h0}, 8'h00, 1'b0);
            chk("clear sel", 2'h0, clear_code_select);
            chk("hs mode", hx[i], hs_mode);
            chk("code A", 12'h000, dac_code[0]);
            chk("load mask", 8'h00, load_pin_mask);
        end
        report_and_stop();
    end
endmodule : odwcd_decoder_tb

// ---- sim/odwcd_host_model.sv ----
// Host model that sends write frames over the byte link.
// Assumes the caller leaves enough idle time between frames.
`timescale 1ns/1ps
module odwcd_host_model (
    // Link outputs
    output logic       link_clk,
    output logic       link_start,
    output logic       link_byte_valid,
    output logic [7:0] link_byte
);
    // Idle link: clock stands still between frames
    initial begin
        link_clk        = 1'b0;
        link_start      = 1'b0;
        link_byte_valid = 1'b0;
        link_byte       = 8'h00;
    end

    // Command byte, then MSB, then LSB, on a 6 ns link clock.
    // Each byte is set at the rising edge before the one that takes it;
    // the fourth edge releases the lines, showing the inverse byte.
    task automatic send(input logic [7:0] b0, b1, b2);
        logic [7:0] f [4];
        f = '{b0, b1, b2, ~b2};
        for (int i = 0; i < 4; i++) begin
            #3 link_clk = 1'b1;
            link_start      <= (i == 0);
            link_byte_valid <= (i < 3);
            link_byte       <= f[i];
            #3 link_clk = 1'b0;
        end
    endtask : send
endmodule : odwcd_host_model

// ---- verilog/odwcd_chan_bank.sv ----
// Input and output code registers for the eight converter channels.
// Assumes write, update and clear strobes come from the core clock domain.
`timescale 1ns/1ps
module odwcd_chan_bank (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              soft_rst,
    // Write and update strobes
    input  wire logic [7:0]        wr_en,
    input  wire logic [11:0]       wr_code,
    input  wire logic [7:0]        upd_en,
    // Clear pin action
    input  wire logic              clr_en,
    input  wire logic [11:0]       clr_code,
    // Output codes
    output logic      [7:0][11:0]  dac_code
);
    logic [7:0][11:0] in_q;         // Input registers

    for (genvar ch = 0; ch < odwcd_pkg::NCH; ch++) begin : g_ch
        // Input register: a write lands here first
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                in_q[ch] <= odwcd_pkg::CODE_RST;
            end else if (soft_rst) begin
                in_q[ch] <= odwcd_pkg::CODE_RST;
            end else if (wr_en[ch]) begin
                in_q[ch] <= wr_code;
            end
        end

        // Output register: an update in the write cycle sees new data
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                dac_code[ch] <= odwcd_pkg::CODE_RST;
            end else if (soft_rst) begin
                dac_code[ch] <= odwcd_pkg::CODE_RST;
            end else if (clr_en) begin
                dac_code[ch] <= clr_code;   // Clear pin beats updates
            end else if (upd_en[ch]) begin
                dac_code[ch] <= wr_en[ch] ? wr_code : in_q[ch];
            end
        end
    end
endmodule : odwcd_chan_bank

// ---- verilog/odwcd_decoder.sv ----
// Write-command decoder for an eight-channel converter on a two-wire link.
// Assumes a byte receiver on link_clk delivers frame bytes with a start mark;
// the load and clear pins arrive asynchronously, active low.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Operation
// RL1: Code 0010 channel H: load H, update all
// RL2: Code 0010 bad address: ignore frame entirely
// RL3: Address 1111: load all, update all
// RL4: 12-bit word: first byte, upper nibble next
// RL5: 10-bit word: first byte, top two bits
// RL6: 8-bit word: first byte only
// RL7: Power mode 00 powers on masked channels
// RL8: Modes 01/10/11 power down masked channels
// RL9: Code 0101 selects clear pin target
// RL10: Load mask bit 1 ignores load pin
// RL11: Load mask bit 0 follows load pin
// RL12: Reset kind 00 restores power-on state
// RL13: Reset kind 01 enters high-speed mode
// RL14: Reset kind 10 keeps high-speed state
// RL15: Code 0011 loads, updates only that channel
// RL16: Host sends command, MSB, LSB bytes
// RL17: Unknown commands change nothing
// RL18: Reset kind 11 acts as default reset
module odwcd_decoder (
    // Core clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Link side, synchronous to link_clk
    input  wire logic             link_clk,
    input  wire logic             link_start,
    input  wire logic             link_byte_valid,
    input  wire logic [7:0]       link_byte,
    // Device pins, asynchronous, active low
    input  wire logic             load_update_pin_n,
    input  wire logic             async_clear_pin_n,
    // Channel outputs
    output logic      [7:0][11:0] dac_code,
    output logic      [7:0][1:0]  chan_power_mode,
    // Register contents
    output logic      [9:0]       channel_power_control,
    output logic      [1:0]       clear_code_select,
    output logic      [7:0]       load_pin_mask,
    output logic                  hs_mode,
    // Frame status
    output logic                  frame_done,
    output logic                  frame_drop
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame assembly

    logic [1:0]  lnk_cnt_q;         // Bytes seen in this frame
    logic [7:0]  lnk_b0_q;          // Command byte
    logic [7:0]  lnk_b1_q;          // First data byte
    logic [23:0] lnk_frame_q;       // Whole frame, held for the core
    logic        lnk_tog_q;         // Flips once per complete frame

    // Collect three bytes; the third publishes the frame by a toggle.
    // Extra bytes are dropped, so the held frame stays stable.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_cnt_q   <= odwcd_pkg::BYTE_CNT_RST;
            lnk_b0_q    <= 8'h00;
            lnk_b1_q    <= 8'h00;
            lnk_frame_q <= 24'h000000;
            lnk_tog_q   <= 1'b0;
        end else if (link_byte_valid && link_start) begin
            lnk_b0_q  <= link_byte;             // Command comes first [RL16]
            lnk_cnt_q <= 2'h1;
        end else if (link_byte_valid) begin
            unique case (lnk_cnt_q)
                2'h1: begin
                    lnk_b1_q  <= link_byte;
                    lnk_cnt_q <= 2'h2;
                end
                2'h2: begin
                    lnk_frame_q <= {lnk_b0_q, lnk_b1_q, link_byte};
                    lnk_tog_q   <= ~lnk_tog_q;
                    lnk_cnt_q   <= 2'h3;
                end
                default: begin
                    lnk_cnt_q <= lnk_cnt_q; // No start yet or overrun
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the core domain

    logic        tog_s;             // Synchronised frame toggle
    logic        load_pin_s_n;      // Synchronised load pin
    logic        clear_pin_s_n;     // Synchronised clear pin

    // Pins idle high, toggle idles low
    odwcd_sync2 #(
        .W       (3),
        .RST_VAL (3'h6)
    ) u_sync (
        .clk   (core_clk),
        .rst_n (rst_n),
        .d     ({load_update_pin_n, async_clear_pin_n, lnk_tog_q}),
        .q     ({load_pin_s_n, clear_pin_s_n, tog_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // Core sequencer

    odwcd_pkg::odwcd_state_t state_q;
    logic        tog_seen_q;        // Toggle value already consumed
    logic [23:0] frame_q;           // Frame copy in the core domain
    logic        new_frame;

    assign new_frame = (tog_s != tog_seen_q);

    // Idle, take the frame word once its toggle has settled, then execute.
    // The link word was written two syncs earlier, so it is stable here.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= odwcd_pkg::ST_IDLE;
            tog_seen_q <= 1'b0;
            frame_q    <= 24'h000000;
        end else begin
            unique case (state_q)
                odwcd_pkg::ST_IDLE: begin
                    if (new_frame) begin
                        tog_seen_q <= tog_s;
                        state_q    <= odwcd_pkg::ST_TAKE;
                    end
                end
                odwcd_pkg::ST_TAKE: begin
                    frame_q <= lnk_frame_q;
                    state_q <= odwcd_pkg::ST_EXEC;
                end
                odwcd_pkg::ST_EXEC: begin
                    state_q <= odwcd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [7:0]  msb;
    logic [7:0]  lsb;
    logic        exec;
    logic        is_wr;
    logic        wr_ok;
    logic        bcast;
    logic [11:0] wdata;
    logic [1:0]  pmode;
    logic [7:0]  pmask;
    logic [1:0]  rst_kind;
    logic        known;

    assign cmd      = frame_q[23:20];
    assign addr     = frame_q[19:16];
    assign msb      = frame_q[15:8];
    assign lsb      = frame_q[7:0];
    assign exec     = (state_q == odwcd_pkg::ST_EXEC);
    assign is_wr    = (cmd == odwcd_pkg::CMD_WR_UPD_ALL)
                   || (cmd == odwcd_pkg::CMD_WR_UPD_ONE);
    assign bcast    = (addr == odwcd_pkg::ADDR_BCAST);               // [RL3]
    assign wr_ok    = is_wr && (!addr[3] || bcast);                  // [RL2]
    assign wdata    = odwcd_pkg::data_word(msb, lsb);     // [RL4] [RL5] [RL6]
    assign pmode    = msb[odwcd_pkg::PWR_MODE_HI:odwcd_pkg::PWR_MODE_LO];
    assign pmask    = {msb[odwcd_pkg::PWR_MASK_HI:0],
                       lsb[7:odwcd_pkg::PWR_MASK_LO]};     // H down to A
    assign rst_kind = msb[odwcd_pkg::RST_KIND_HI:odwcd_pkg::RST_KIND_LO];
    // Reads and upper codes are not ours: they fall through untouched
    assign known    = wr_ok || (cmd == odwcd_pkg::CMD_POWER)
                   || (cmd == odwcd_pkg::CMD_CLEAR)
                   || (cmd == odwcd_pkg::CMD_LOAD_MASK)
                   || (cmd == odwcd_pkg::CMD_SOFT_RST);              // [RL17]

    ////////////////////////////////////////////////////////////////////////
    // Channel strobes

    logic        srst;              // Software reset, one cycle
    logic [7:0]  wr_en;
    logic [7:0]  upd_en;
    logic        ld_act;            // Load pin held low
    logic        clr_en;            // Clear pin low and enabled
    logic [11:0] clr_code;

    assign srst   = exec && (cmd == odwcd_pkg::CMD_SOFT_RST);
    assign ld_act = !load_pin_s_n;
    assign clr_en = !clear_pin_s_n
                 && (clear_code_select != odwcd_pkg::CLR_OFF);       // [RL9]

    // Decode writes and the three update sources
    always_comb begin
        wr_en  = 8'h00;
        upd_en = 8'h00;
        if (exec && wr_ok) begin
            wr_en = bcast ? 8'hff : 8'(1 << addr[2:0]);       // [RL1] [RL3]
            if (bcast || cmd == odwcd_pkg::CMD_WR_UPD_ALL) begin
                upd_en = 8'hff;                               // [RL1] [RL3]
            end else begin
                upd_en = wr_en;                                     // [RL15]
            end
        end
        // Unmasked channels follow the load pin level
        if (ld_act) begin
            upd_en = upd_en | ~load_pin_mask;              // [RL10] [RL11]
        end
    end

    // Clear target at the built resolution
    always_comb begin
        unique case (clear_code_select)
            odwcd_pkg::CLR_MID:  clr_code = odwcd_pkg::CODE_MID;
            odwcd_pkg::CLR_FULL: clr_code = odwcd_pkg::CODE_FULL;
            default:             clr_code = odwcd_pkg::CODE_ZERO;
        endcase
    end

    odwcd_chan_bank u_bank (
        .clk      (core_clk),
        .rst_n    (rst_n),
        .soft_rst (srst),
        .wr_en    (wr_en),
        .wr_code  (wdata),
        .upd_en   (upd_en),
        .clr_en   (clr_en),
        .clr_code (clr_code),
        .dac_code (dac_code)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    // Power: masked channels take the new mode, others keep theirs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_power_mode       <= {8{odwcd_pkg::PWR_MODE_RST}};
            channel_power_control <= odwcd_pkg::PWR_CTRL_RST;
        end else if (srst) begin
            chan_power_mode       <= {8{odwcd_pkg::PWR_MODE_RST}};  // [RL12]
            channel_power_control <= odwcd_pkg::PWR_CTRL_RST;
        end else if (exec && cmd == odwcd_pkg::CMD_POWER) begin
            channel_power_control <= {pmode, pmask};
            for (int ch = 0; ch < odwcd_pkg::NCH; ch++) begin
                if (pmask[ch]) begin
                    chan_power_mode[ch] <= pmode;           // [RL7] [RL8]
                end
            end
        end
    end

    // Clear code selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clear_code_select <= odwcd_pkg::CLR_SEL_RST;
        end else if (srst) begin
            clear_code_select <= odwcd_pkg::CLR_SEL_RST;
        end else if (exec && cmd == odwcd_pkg::CMD_CLEAR) begin
            clear_code_select <=
                lsb[odwcd_pkg::CLR_SEL_HI:odwcd_pkg::CLR_SEL_LO];    // [RL9]
        end
    end

    // Load pin mask, channel H in bit 7
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pin_mask <= odwcd_pkg::LOAD_MASK_RST;
        end else if (srst) begin
            load_pin_mask <= odwcd_pkg::LOAD_MASK_RST;
        end else if (exec && cmd == odwcd_pkg::CMD_LOAD_MASK) begin
            load_pin_mask <= msb;                                   // [RL10]
        end
    end

    // High-speed flag; kind 11 behaves as the default reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_mode <= odwcd_pkg::HS_RST;
        end else if (srst) begin
            unique case (rst_kind)
                odwcd_pkg::RST_HS_SET:  hs_mode <= 1'b1;            // [RL13]
                odwcd_pkg::RST_HS_KEEP: hs_mode <= hs_mode;         // [RL14]
                default: hs_mode <= odwcd_pkg::HS_RST;       // [RL12] [RL18]
            endcase
        end
    end

    // Frame outcome pulses
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_done <= 1'b0;
            frame_drop <= 1'b0;
        end else begin
            frame_done <= exec;
            frame_drop <= exec && !known;                  // [RL2] [RL17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_chan_h_global: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && cmd == 4'h2 && addr == 4'h7 && !clr_en
        |=> dac_code[7] == $past(wdata) && frame_done)   // [RL1]
        else $error("channel H global write not applied");

    a_bad_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && cmd == 4'h2 && addr[3] && addr != 4'hf && !ld_act && !clr_en
        |=> $stable(dac_code) && frame_drop)   // [RL2]
        else $error("invalid address changed outputs");

    a_bcast_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && is_wr && addr == 4'hf && !clr_en
        |=> dac_code[0] == $past(wdata) && dac_code[7] == $past(wdata))   // [RL3]
        else $error("broadcast did not reach every channel");

    a_data_align: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && is_wr && addr == 4'h0 && !clr_en
        && odwcd_pkg::RES_BITS == 12
        |=> dac_code[0] == {$past(msb), $past(lsb[7:4])})   // [RL4]
        else $error("data word misaligned");

    a_single_update: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && cmd == 4'h3 && addr == 4'h0 && !ld_act && !clr_en
        |=> dac_code[0] == $past(wdata)
            && dac_code[1] == $past(dac_code[1]))   // [RL15]
        else $error("single-channel update touched another channel");

    a_power_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && cmd == 4'h4 && pmask[1] && !pmask[0]
        |=> chan_power_mode[1] == $past(pmode)
            && $stable(chan_power_mode[0]))   // [RL7] [RL8]
        else $error("power mode not applied by mask");

    a_clear_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && cmd == 4'h5
        |=> clear_code_select == $past(lsb[5:4]) ##1 !frame_done)   // [RL9]
        else $error("clear selection not stored");

    a_load_mask: assert property (@(posedge core_clk) disable iff (!rst_n)
        ld_act && load_pin_mask[4] && !exec |-> !upd_en[4])   // [RL10] [RL11]
        else $error("masked channel followed the load pin");

    a_reset_kinds: assert property (@(posedge core_clk) disable iff (!rst_n)
        srst |=> load_pin_mask == 8'h00 && clear_code_select == 2'h0
        && hs_mode == ($past(rst_kind) == 2'h1
                   || ($past(rst_kind) == 2'h2 && $past(hs_mode))))
        // [RL12] [RL13] [RL14] [RL18]
        else $error("software reset outcome wrong");

    a_unknown_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
        exec && !known |=> $stable(load_pin_mask)
        && $stable(clear_code_select) && $stable(channel_power_control))   // [RL17]
        else $error("unknown command changed a register");

    a_frame_latency: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == odwcd_pkg::ST_IDLE && new_frame |-> ##3 frame_done)
        else $error("frame not executed in three cycles");

endmodule : odwcd_decoder

// ---- verilog/odwcd_pkg.sv ----
// Constants, types and helpers shared by the octal converter command decoder.
// Assumes a 24-bit write frame: command byte, then two data bytes.
package odwcd_pkg;

    // Build variant: 8, 10 or 12 bits of converter resolution
    localparam int          RES_BITS       = 12;
    localparam int          NCH            = 8;     // Channels A..H
    localparam int          CODE_W         = 12;    // Stored code width

    // Command nibbles
    localparam logic [3:0]  CMD_WR_UPD_ALL = 4'h2;  // Load one, update all
    localparam logic [3:0]  CMD_WR_UPD_ONE = 4'h3;  // Load one, update it
    localparam logic [3:0]  CMD_POWER      = 4'h4;
    localparam logic [3:0]  CMD_CLEAR      = 4'h5;
    localparam logic [3:0]  CMD_LOAD_MASK  = 4'h6;
    localparam logic [3:0]  CMD_SOFT_RST   = 4'h7;
    localparam logic [3:0]  ADDR_BCAST     = 4'hf;

    // Field positions inside the data bytes
    localparam int          PWR_MODE_HI    = 6;     // First data byte
    localparam int          PWR_MODE_LO    = 5;
    localparam int          PWR_MASK_HI    = 4;     // First byte, channel H
    localparam int          PWR_MASK_LO    = 5;     // Second byte, channel A
    localparam int          CLR_SEL_HI     = 5;     // Second data byte
    localparam int          CLR_SEL_LO     = 4;
    localparam int          RST_KIND_HI    = 7;     // First data byte
    localparam int          RST_KIND_LO    = 6;

    // Power modes
    localparam logic [1:0]  PWR_ON         = 2'h0;
    localparam logic [1:0]  PWR_DN_1K      = 2'h1;
    localparam logic [1:0]  PWR_DN_100K    = 2'h2;
    localparam logic [1:0]  PWR_DN_HIZ     = 2'h3;

    // Clear codes
    localparam logic [1:0]  CLR_ZERO       = 2'h0;
    localparam logic [1:0]  CLR_MID        = 2'h1;
    localparam logic [1:0]  CLR_FULL       = 2'h2;
    localparam logic [1:0]  CLR_OFF        = 2'h3;

    // Software reset kinds
    localparam logic [1:0]  RST_DEFAULT    = 2'h0;
    localparam logic [1:0]  RST_HS_SET     = 2'h1;
    localparam logic [1:0]  RST_HS_KEEP    = 2'h2;

    // Reset values
    localparam logic [1:0]  PWR_MODE_RST   = 2'h0;
    localparam logic [9:0]  PWR_CTRL_RST   = 10'h000;
    localparam logic [1:0]  CLR_SEL_RST    = 2'h0;
    localparam logic [7:0]  LOAD_MASK_RST  = 8'h00;
    localparam logic [11:0] CODE_RST       = 12'h000;
    localparam logic        HS_RST         = 1'b0;

    // Clear target codes at the built resolution
    localparam logic [11:0] CODE_ZERO      = 12'h000;
    localparam logic [11:0] CODE_MID       = 12'(1 << (RES_BITS - 1));
    localparam logic [11:0] CODE_FULL      = 12'((1 << RES_BITS) - 1);

    // Link framing
    localparam logic [1:0]  BYTE_CNT_RST   = 2'h0;

    // Core sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TAKE = 3'b010,
        ST_EXEC = 3'b100
    } odwcd_state_t;

    // Right-aligned data word from the two data bytes
    function automatic logic [11:0] data_word(input logic [7:0] msb,
                                              input logic [7:0] lsb);
        logic [11:0] w;
        w = {msb, lsb[7:4]};
        if (RES_BITS == 10) w = {2'h0, msb, lsb[7:6]};
        else if (RES_BITS == 8) w = {4'h0, msb};
        return w;
    endfunction : data_word

endpackage : odwcd_pkg

// ---- verilog/odwcd_sync2.sv ----
// Two-flop level synchroniser for signals entering the core clock domain.
// Assumes each bit is a slow level; multi-bit words are not coherent.
`timescale 1ns/1ps
module odwcd_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;   // First stage, read only by the second

    // Plain two-stage chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : odwcd_sync2
